/* File: rtl/gpm_panel.sv */
`default_nettype none
module gpm_panel #(
   // five minutes of cycles exceeds 32 bits, so this one count is 64-bit
   parameter longint SLEEP_CYC = longint'(gpm_pkg::SLEEP_S) * gpm_pkg::CLK_HZ,
   parameter int LAMP_CYC = gpm_pkg::LAMP_TEST_S * gpm_pkg::CLK_HZ,
   parameter int HOLD_CYC = gpm_pkg::HOLD_S * gpm_pkg::CLK_HZ,
   parameter int MANUAL_CYC = gpm_pkg::MANUAL_S * gpm_pkg::CLK_HZ,
   parameter int DEB_CYC = gpm_pkg::DEBOUNCE_CYC,
   parameter int IDLE_RPM = 800,
   parameter int RPM_W = gpm_pkg::RPM_W
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // panel buttons, raw
   input wire logic [gpm_pkg::NBTN-1:0] btn_raw,
   // emergency stop knob, high while pushed in
   input wire logic estop_in,
   // transfer switch
   input wire logic remote_run,
   // engine and fault conditions
   input wire logic shutdown_cond,
   input wire logic warning_cond,
   input wire logic [RPM_W-1:0] engine_rpm,
   input wire logic freq_50hz,
   input wire logic volt_ok,
   input wire logic warming,
   input wire logic cooling,
   // SAPB registers
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // engine and breaker commands
   output logic run_cmd,
   output logic fast_stop,
   output logic brk_close_en,
   output logic brk_open_cmd,
   // indicators
   output gpm_pkg::gpm_lamps_t lamps,
   output logic ext_lamp,
   output logic display_on,
   output logic warn_display,
   output gpm_pkg::gpm_status_t status
);
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STAT = 12'h004;

   logic [gpm_pkg::NBTN-1:0] s1, s2, deb, deb_d;
   logic [gpm_pkg::NBTN-1:0] press;
   genvar gi;
   generate
      for (gi = 0; gi < gpm_pkg::NBTN; gi++) begin : g_btn
         logic [31:0] dcnt;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               dcnt <= 32'h0;
               deb[gi] <= 1'b0;
            end else if (s2[gi] == deb[gi]) begin
               dcnt <= 32'h0;
            end else if (dcnt >= 32'(DEB_CYC - 1)) begin
               dcnt <= 32'h0;
               deb[gi] <= s2[gi];
            end else begin
               dcnt <= dcnt + 32'h1;
            end
         end
      end
   endgenerate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1 <= '0;
         s2 <= '0;
         deb_d <= '0;
      end else begin
         s1 <= btn_raw;
         s2 <= s1;
         deb_d <= deb;
      end
   end
   assign press = deb & ~deb_d;

   // sleep and wake: the waking press is swallowed
   logic asleep;
   logic [35:0] idle_cnt;
   logic fault_unack;
   wire any_press = |press;
   wire awake_press = any_press & ~asleep;
   wire p_stop = awake_press & press[gpm_pkg::B_STOP];
   wire p_man = awake_press & press[gpm_pkg::B_MANUAL];
   wire p_auto = awake_press & press[gpm_pkg::B_AUTO];
   wire p_start = awake_press & press[gpm_pkg::B_START];
   wire p_reset = awake_press & press[gpm_pkg::B_RESET];
   wire p_lamp = awake_press & press[gpm_pkg::B_LAMP];
   wire p_bclose = awake_press & press[gpm_pkg::B_BRK_CLOSE];
   wire p_bopen = awake_press & press[gpm_pkg::B_BRK_OPEN];
   wire sleep_due = idle_cnt >= 36'(SLEEP_CYC - 1);

   // emergency stop latch, cleared only by local buttons in order
   gpm_pkg::gpm_es_t es, next_es;
   wire es_latched = es != gpm_pkg::GPM_ES_CLEAR;
   wire p_mode = p_stop | p_man | p_auto;
   always_comb begin
      next_es = es;
      case (es)
         gpm_pkg::GPM_ES_CLEAR: if (estop_in) next_es = gpm_pkg::GPM_ES_LATCHED;
         gpm_pkg::GPM_ES_LATCHED: if (!estop_in && p_stop) next_es = gpm_pkg::GPM_ES_ACKED;
         gpm_pkg::GPM_ES_ACKED: if (p_reset) next_es = gpm_pkg::GPM_ES_RESET;
         gpm_pkg::GPM_ES_RESET: if (p_mode) next_es = gpm_pkg::GPM_ES_CLEAR;
         default: next_es = gpm_pkg::GPM_ES_LATCHED;
      endcase
      if (estop_in) next_es = gpm_pkg::GPM_ES_LATCHED;
   end

   // shutdown latch: Stop arms, Reset clears once cause gone
   logic sd_latch, sd_stop_seen, warn_hidden, sd_stop_req;
   wire sd_clear = p_reset & sd_stop_seen;

   // mode and manual window
   gpm_pkg::gpm_mode_t mode;
   logic [31:0] man_cnt;
   logic man_started;
   wire inhibit = es_latched | sd_latch | shutdown_cond;
   wire man_window = (mode == gpm_pkg::GPM_MANUAL) & ~man_started;
   wire man_timeout = man_window & (man_cnt >= 32'(MANUAL_CYC - 1));
   wire rated_rpm = freq_50hz ? (engine_rpm >= RPM_W'(gpm_pkg::RPM_50HZ)) :
                                (engine_rpm >= RPM_W'(gpm_pkg::RPM_60HZ));
   wire at_rated = rated_rpm & volt_ok;
   wire want_run = ~inhibit & ~asleep &
                   ((mode == gpm_pkg::GPM_AUTO & remote_run) |
                    (mode == gpm_pkg::GPM_MANUAL & man_started));
   wire fault_stop = es_latched | sd_latch | shutdown_cond;

   // lamp test
   logic [31:0] lt_cnt, hold_cnt;
   logic hold_done;
   wire lamp_test = lt_cnt != 32'h0;

   // control register from software: bit0 blocks remote run
   logic ctrl_remote_block;
   wire setup = psel & ~penable;
   wire acc = psel & penable;
   wire hit_ctrl = paddr == ADDR_CTRL;
   wire hit_stat = paddr == ADDR_STAT;
   wire bad = ~(hit_ctrl | hit_stat);
   wire [31:0] rd_val = hit_ctrl ? {31'h0, ctrl_remote_block} :
                        hit_stat ? {22'h0, es_latched, sd_latch, warn_hidden, asleep,
                                    status, 2'(mode), run_cmd, man_started} : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         asleep <= 1'b0;
         idle_cnt <= 36'h0;
         fault_unack <= 1'b0;
      end else begin
         if (any_press) idle_cnt <= 36'h0;
         else if (!sleep_due) idle_cnt <= idle_cnt + 36'h1;
         if (any_press) asleep <= 1'b0;
         else if (sleep_due && !fault_unack && !run_cmd) asleep <= 1'b1;
         if (shutdown_cond || warning_cond || estop_in) fault_unack <= 1'b1;
         else if (p_reset) fault_unack <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) es <= gpm_pkg::GPM_ES_CLEAR;
      else es <= next_es;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sd_latch <= 1'b0;
         sd_stop_seen <= 1'b0;
         warn_hidden <= 1'b0;
      end else begin
         if (shutdown_cond) sd_latch <= 1'b1;
         else if (sd_clear) sd_latch <= 1'b0;
         if (shutdown_cond || !sd_latch) sd_stop_seen <= 1'b0;
         else if (p_stop) sd_stop_seen <= 1'b1;
         if (!warning_cond) warn_hidden <= 1'b0;
         else if (p_reset) warn_hidden <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= gpm_pkg::GPM_OFF;
         man_cnt <= 32'h0;
         man_started <= 1'b0;
      end else if (!asleep) begin
         if (p_stop || man_timeout) begin
            mode <= gpm_pkg::GPM_OFF;
            man_started <= 1'b0;
         end else if (p_auto) begin
            mode <= gpm_pkg::GPM_AUTO;
            man_started <= 1'b0;
         end else if (p_man) begin
            mode <= gpm_pkg::GPM_MANUAL;
            man_cnt <= 32'h0;
            man_started <= 1'b0;
         end else if (man_window) begin
            if (p_start && !inhibit) man_started <= 1'b1;
            else man_cnt <= man_cnt + 32'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lt_cnt <= 32'h0;
         hold_cnt <= 32'h0;
         hold_done <= 1'b0;
         ext_lamp <= 1'b0;
      end else begin
         if (p_lamp) lt_cnt <= 32'(LAMP_CYC);
         else if (lamp_test) lt_cnt <= lt_cnt - 32'h1;
         if (!deb[gpm_pkg::B_LAMP] || asleep) begin
            hold_cnt <= 32'h0;
            hold_done <= 1'b0;
         end else if (!hold_done) begin
            if (hold_cnt >= 32'(HOLD_CYC - 1)) begin
               hold_done <= 1'b1;
               ext_lamp <= ~ext_lamp;
            end else begin
               hold_cnt <= hold_cnt + 32'h1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_cmd <= 1'b0;
         fast_stop <= 1'b0;
         brk_close_en <= 1'b0;
         brk_open_cmd <= 1'b0;
      end else begin
         // software block on remote run gates the run command in Auto only, so it also stops an engine already running in Auto
         run_cmd <= want_run & ~(mode == gpm_pkg::GPM_AUTO & ctrl_remote_block);
         fast_stop <= fault_stop;
         if (mode != gpm_pkg::GPM_MANUAL || !at_rated || fault_stop || p_bopen)
            brk_close_en <= 1'b0;
         else if (p_bclose) brk_close_en <= 1'b1;
         brk_open_cmd <= (p_bopen & mode == gpm_pkg::GPM_MANUAL) | fault_stop;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lamps <= '0;
         display_on <= 1'b0;
         warn_display <= 1'b0;
         status <= gpm_pkg::GPM_READY;
      end else begin
         display_on <= ~asleep;
         warn_display <= ~asleep & warning_cond & ~warn_hidden;
         if (engine_rpm == '0) status <= gpm_pkg::GPM_READY;
         else if (at_rated) status <= gpm_pkg::GPM_RUNNING;
         else if (engine_rpm < RPM_W'(IDLE_RPM)) status <= gpm_pkg::GPM_STARTING;
         if (asleep) lamps <= '0;
         else if (lamp_test) lamps <= '1;
         else begin
            lamps.not_auto <= mode != gpm_pkg::GPM_AUTO;
            lamps.shutdown <= sd_latch | shutdown_cond | es_latched;
            lamps.warning <= warning_cond;
            lamps.auto_sel <= mode == gpm_pkg::GPM_AUTO;
            lamps.off_sel <= mode == gpm_pkg::GPM_OFF;
            lamps.manual_sel <= mode == gpm_pkg::GPM_MANUAL;
            lamps.running <= at_rated & ~warming & ~cooling;
            lamps.remote <= remote_run;
         end
      end
   end

   // APB slave, zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_remote_block <= 1'b0;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & bad;
         if (setup && !pwrite) prdata <= rd_val;
         if (acc && pwrite && hit_ctrl) ctrl_remote_block <= pwdata[0];
      end
   end
endmodule
`default_nettype wire

/* File: rtl/gpm_pkg.sv */
// Behaviour
// - after five minutes without keypad activity, sleep, unless an unacknowledged fault exists; the code also stays awake while run_cmd is high.
// - asleep, all lamps and display are off and operating logic is held.
// - a button press while asleep only wakes the panel, never starts.
// - latched emergency stop stops the engine and blocks all start requests.
// - estop clears only by knob released, Stop, Reset, then a mode button.
// - the estop clearing sequence is taken only from local panel buttons.
// - short lamp test press lights every lamp for five seconds.
// - holding lamp test three seconds toggles the external panel lamp.
// - not-in-auto lamp is lit whenever mode is not Auto.
// - shutdown lamp latches, blocks start, clears by Stop then Reset once gone.
// - Reset clears faults; shutdown with persisting cause comes back at once.
// - after Reset a persisting warning stays raised but its display is hidden.
// - amber warning lamp follows any warning condition directly.
// - Auto button selects Auto; in Auto the run follows remote run input.
// - Stop selects Off, lights its lamp and shuts down a running engine.
// - Start within ten seconds of selecting Manual begins a start; else ignored.
// - without Start in ten seconds Manual falls back to Off; Manual lamp shown.
// - breaker close is permitted in Manual only, at speed and voltage.
// - breaker open button opens the breaker in Manual only.
// - running lamp lit only at rated speed and voltage, not warm-up or cool-down.
// - remote start lamp shows remote run; it acts only in Auto.
// - status Ready by default, Starting below idle, Running at rated speed.
// - shutdown fault drops load and stops with no cool-down; warning indicates only.
`default_nettype none
package gpm_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int SLEEP_S = 300;
   localparam int LAMP_TEST_S = 5;
   localparam int HOLD_S = 3;
   localparam int MANUAL_S = 10;
   localparam int DEBOUNCE_MS = 10;
   localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int RPM_60HZ = 1800;
   localparam int RPM_50HZ = 1500;
   localparam int RPM_W = 12;
   localparam int NBTN = 8;
   localparam int B_STOP = 0;
   localparam int B_MANUAL = 1;
   localparam int B_AUTO = 2;
   localparam int B_START = 3;
   localparam int B_RESET = 4;
   localparam int B_LAMP = 5;
   localparam int B_BRK_CLOSE = 6;
   localparam int B_BRK_OPEN = 7;
   typedef enum logic [1:0] {GPM_OFF, GPM_MANUAL, GPM_AUTO} gpm_mode_t;
   typedef enum logic [1:0] {GPM_READY, GPM_STARTING, GPM_RUNNING} gpm_status_t;
   typedef enum logic [1:0] {GPM_ES_CLEAR, GPM_ES_LATCHED, GPM_ES_ACKED, GPM_ES_RESET} gpm_es_t;
   typedef struct packed {
      logic not_auto;
      logic shutdown;
      logic warning;
      logic auto_sel;
      logic off_sel;
      logic manual_sel;
      logic running;
      logic remote;
   } gpm_lamps_t;
endpackage
`default_nettype wire

/* File: bench/gpm_operator.sv */
`default_nettype none
module gpm_operator (
   // clock
   input wire logic pclk,
   // panel buttons and transfer switch
   output logic [gpm_pkg::NBTN-1:0] btn_raw,
   output logic remote_run
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      btn_raw = 8'h00;
      remote_run = 1'b0;
   end
   // hold past sync and debounce, release long enough to count as a new press
   task automatic press(input int b, input int n);
      @(posedge pclk) btn_raw[b] <= 1'b1;
      repeat (n) @(posedge pclk);
      btn_raw[b] <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask
   task automatic set_remote(input logic v);
      @(posedge pclk) remote_run <= v;
   endtask
endmodule
`default_nettype wire

/* File: bench/gpm_checker.sv */
`default_nettype none
module gpm_checker #(
   parameter int RPM_W = 12
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // watched inputs
   input wire logic estop_in,
   input wire logic remote_run,
   input wire logic shutdown_cond,
   input wire logic [RPM_W-1:0] engine_rpm,
   input wire logic freq_50hz,
   input wire logic warming,
   input wire logic cooling,
   input wire logic psel,
   input wire logic penable,
   // watched outputs
   input wire logic pready,
   input wire logic run_cmd,
   input wire logic fast_stop,
   input wire gpm_pkg::gpm_lamps_t lamps,
   input wire logic display_on,
   input wire gpm_pkg::gpm_status_t status
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence sd_held;
      shutdown_cond [*2];
   endsequence
   sequence rated_held;
      (engine_rpm == (freq_50hz ? 12'h5DC : 12'h708)) [*3];
   endsequence
   estop_halt_a: assert property (estop_in [*2] |-> ##[0:6] (!run_cmd && fast_stop))
      else $error("engine not halted under emergency stop");
   sleep_dark_a: assert property (!display_on |-> lamps == 8'h00)
      else $error("lamp lit while asleep");
   start_block_a: assert property ($rose(run_cmd) |-> !fast_stop)
      else $error("run raised while stop forced");
   sd_drop_a: assert property (sd_held |-> ##[0:3] (fast_stop && !run_cmd))
      else $error("shutdown did not drop the engine");
   ready_idle_a: assert property ((engine_rpm == 12'h000) [*3] |-> status == gpm_pkg::GPM_READY)
      else $error("status not ready at standstill");
   rated_run_a: assert property (rated_held |-> status == gpm_pkg::GPM_RUNNING)
      else $error("status not running at rated speed");
   run_lamp_a: assert property ((warming || cooling) [*3] |-> !lamps.running || lamps == 8'hFF)
      else $error("running lamp lit in warm-up or cool-down");
   remote_lamp_a: assert property ((remote_run && display_on) [*4] |-> lamps.remote)
      else $error("remote lamp dark with remote run");
   apb_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready in access cycle");
endmodule
bind gpm_panel gpm_checker #(.RPM_W(RPM_W)) i_gpm_checker (.pclk(pclk), .presetn(presetn),
   .estop_in(estop_in), .remote_run(remote_run), .shutdown_cond(shutdown_cond),
   .engine_rpm(engine_rpm), .freq_50hz(freq_50hz), .warming(warming), .cooling(cooling),
   .psel(psel), .penable(penable), .pready(pready), .run_cmd(run_cmd), .fast_stop(fast_stop),
   .lamps(lamps), .display_on(display_on), .status(status));
`default_nettype wire

/* File: bench/test_genset_panel_mode_control.sv */
`default_nettype none
module test_genset_panel_mode_control;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SLP = 200;
   localparam int LMP = 50;
   localparam int HLD = 30;
   localparam int MAN = 100;
   logic pclk, presetn, estop_in, shutdown_cond, warning_cond, freq_50hz, volt_ok, warming;
   logic cooling, psel, penable, pwrite, pready, pslverr, run_cmd, fast_stop, brk_close_en;
   logic brk_open_cmd, ext_lamp, display_on, warn_display, remote_run, err, seen;
   logic [7:0] btn_raw;
   logic [11:0] engine_rpm, paddr;
   logic [31:0] pwdata, prdata, rd, v;
   gpm_pkg::gpm_lamps_t lamps;
   gpm_pkg::gpm_status_t status;
   int n_fail, tests_run, m_mode;
   gpm_panel #(.SLEEP_CYC(SLP), .LAMP_CYC(LMP), .HOLD_CYC(HLD), .MANUAL_CYC(MAN), .DEB_CYC(2))
   i_gpm_panel (.pclk(pclk), .presetn(presetn), .btn_raw(btn_raw), .estop_in(estop_in),
      .remote_run(remote_run), .shutdown_cond(shutdown_cond), .warning_cond(warning_cond),
      .engine_rpm(engine_rpm), .freq_50hz(freq_50hz), .volt_ok(volt_ok), .warming(warming),
      .cooling(cooling), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .run_cmd(run_cmd),
      .fast_stop(fast_stop), .brk_close_en(brk_close_en), .brk_open_cmd(brk_open_cmd),
      .lamps(lamps), .ext_lamp(ext_lamp), .display_on(display_on),
      .warn_display(warn_display), .status(status));
   gpm_operator i_gpm_operator (.pclk(pclk), .btn_raw(btn_raw), .remote_run(remote_run));
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic chk(input string what, input logic [31:0] seen_v, input logic [31:0] exp_v);
      tests_run++;
      if (seen_v !== exp_v) begin
         n_fail++;
         $display("unexpected %s expected %0h seen %0h", what, exp_v, seen_v);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int to;
      to = 50;
      @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && --to > 0);
      if (to == 0) n_fail++;
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   // model: mode follows the mode buttons, a press while asleep only wakes
   task automatic tap(input int b, input int n = 6, input bit asleep = 0);
      i_gpm_operator.press(b, n);
      if (!asleep && b == gpm_pkg::B_STOP) m_mode = 0;
      if (!asleep && b == gpm_pkg::B_MANUAL) m_mode = 1;
      if (!asleep && b == gpm_pkg::B_AUTO) m_mode = 2;
   endtask
   task automatic chk_mode();
      chk("mode lamps", {lamps.auto_sel, lamps.off_sel, lamps.manual_sel},
          {m_mode == 2, m_mode == 0, m_mode == 1});
      chk("not auto", lamps.not_auto, m_mode != 2);
      apb(1'b0, 12'h004, 32'h0);
      chk("mode field", rd[3:2], m_mode[1:0]);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      cyc(20000);
      n_fail++;
      wrap_up();
   end
   initial begin
      {presetn, estop_in, shutdown_cond, warning_cond, freq_50hz, volt_ok, warming} = 7'h00;
      {cooling, psel, penable, pwrite, paddr, pwdata, engine_rpm} = '0;
      n_fail = 0;
      tests_run = 0;
      m_mode = 0;
      v = $urandom(59767);
      cyc(2);
      presetn <= 1'b1;
      // registered lamps settle one edge after release
      cyc(2);
      chk_mode();
      chk("status", status, gpm_pkg::GPM_READY);
      v = $urandom;
      apb(1'b1, 12'h000, v);
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl", rd, {31'h0, v[0]});
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped", err, 1'b1);
      $display("reset and register test done");
      tap(gpm_pkg::B_AUTO);
      chk_mode();
      i_gpm_operator.set_remote(1'b1);
      cyc(6);
      chk("auto run", {run_cmd, lamps.remote}, 2'b11);
      estop_in <= 1'b1;
      cyc(6);
      chk("estop", {run_cmd, fast_stop}, 2'b01);
      estop_in <= 1'b0;
      tap(gpm_pkg::B_RESET);
      apb(1'b0, 12'h004, 32'h0);
      chk("estop order", rd[9], 1'b1);
      tap(gpm_pkg::B_STOP);
      tap(gpm_pkg::B_RESET);
      tap(gpm_pkg::B_AUTO);
      apb(1'b0, 12'h004, 32'h0);
      chk("estop clear", {rd[9], run_cmd}, 2'b01);
      tap(gpm_pkg::B_STOP);
      chk_mode();
      chk("stop run", run_cmd, 1'b0);
      i_gpm_operator.set_remote(1'b0);
      $display("auto and estop test done");
      tap(gpm_pkg::B_MANUAL);
      chk_mode();
      cyc(MAN + 10);
      m_mode = 0;
      chk_mode();
      tap(gpm_pkg::B_START);
      chk("start off", run_cmd, 1'b0);
      tap(gpm_pkg::B_MANUAL);
      tap(gpm_pkg::B_START);
      chk("start man", run_cmd, 1'b1);
      engine_rpm <= 12'(1 + $urandom % 799);
      cyc(5);
      chk("starting", status, gpm_pkg::GPM_STARTING);
      {engine_rpm, volt_ok} <= {12'h708, 1'b1};
      cyc(5);
      chk("running", {status, lamps.running}, {gpm_pkg::GPM_RUNNING, 1'b1});
      cooling <= 1'b1;
      cyc(5);
      chk("cool lamp", lamps.running, 1'b0);
      cooling <= 1'b0;
      tap(gpm_pkg::B_BRK_CLOSE);
      chk("brk close", brk_close_en, 1'b1);
      seen = 1'b0;
      fork
         tap(gpm_pkg::B_BRK_OPEN);
         repeat (14) @(posedge pclk) seen |= brk_open_cmd;
      join
      chk("brk open", seen, 1'b1);
      tap(gpm_pkg::B_STOP);
      {engine_rpm, volt_ok} <= 13'h0;
      $display("manual test done");
      tap(gpm_pkg::B_LAMP);
      chk("lamp test", lamps, 8'hFF);
      cyc(LMP);
      chk("lamp after", lamps, 8'h88);
      tap(gpm_pkg::B_LAMP, HLD + 10);
      chk("ext lamp", ext_lamp, 1'b1);
      cyc(LMP);
      $display("lamp test done");
      shutdown_cond <= 1'b1;
      cyc(SLP + 20);
      chk("sd lamp", {lamps.shutdown, fast_stop, display_on}, 3'b111);
      tap(gpm_pkg::B_STOP);
      tap(gpm_pkg::B_RESET);
      chk("sd persists", lamps.shutdown, 1'b1);
      shutdown_cond <= 1'b0;
      tap(gpm_pkg::B_RESET);
      chk("sd no stop", lamps.shutdown, 1'b1);
      tap(gpm_pkg::B_STOP);
      tap(gpm_pkg::B_RESET);
      chk("sd clear", lamps.shutdown, 1'b0);
      warning_cond <= 1'b1;
      cyc(6);
      chk("warn", {lamps.warning, warn_display}, 2'b11);
      tap(gpm_pkg::B_RESET);
      chk("warn hidden", {lamps.warning, warn_display}, 2'b10);
      warning_cond <= 1'b0;
      cyc(6);
      chk("warn gone", lamps.warning, 1'b0);
      // acknowledge the cleared warning so sleep is allowed again
      tap(gpm_pkg::B_RESET);
      $display("fault test done");
      cyc(SLP + 20);
      chk("asleep", {display_on, lamps}, 9'h000);
      tap(gpm_pkg::B_AUTO, 6, 1);
      chk("wake", {display_on, run_cmd}, 2'b10);
      chk_mode();
      $display("sleep test done");
      wrap_up();
   end
endmodule
`default_nettype wire
